// ==== design/dmaac_top.sv ====
`timescale 1ns/1ps

module dmaac_top
	import dmaac_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// memory master
	output logic mem_req,
	output logic mem_write,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic [DATA_W-1:0] mem_wdata,
	input wire logic mem_ready,
	input wire logic [DATA_W-1:0] mem_rdata,
	// peripheral acknowledge, channels 0 and 1
	output logic [1:0] transfer_ack_out,
	// status
	output logic busy
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_CH-1:0][31:0] ctrl_reg;
		logic [NUM_CH-1:0][31:0] src_reg;
		logic [NUM_CH-1:0][31:0] dst_reg;
		logic [NUM_CH-1:0][CNT_W-1:0] cnt_reg;
		dmaac_fsm_type state_reg;
		logic [1:0] cur_reg;
		logic [CNT_W-1:0] rd_left_reg;
		logic dp_write_reg;
		logic [3:0] dp_idx_reg;
		logic [31:0] hrdata_reg;
		logic hreadyout_reg;
		logic hresp_reg;
		logic mem_req_reg;
		logic mem_write_reg;
		logic [31:0] mem_addr_reg;
		logic [1:0] mem_size_reg;
		logic [DATA_W-1:0] mem_wdata_reg;
		logic [1:0] ack_reg;
		logic busy_reg;
	} dmaac_state_type;

	dmaac_state_type r;
	dmaac_state_type r_next;

	logic fifo_push;
	logic fifo_pop;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [31:0] ctrl_mask(input logic [1:0] ch);
		logic [31:0] m;
		m = MASK_COMMON;
		if (ch == 2'h0 || ch == 2'h1) begin
			m = m | MASK_ACK;
		end else if (ch == 2'h3) begin
			m = m | MASK_DEREF;
		end
		return m;
	endfunction

	// reserved mode 11 behaves as fixed; a 16-byte decrement still subtracts 16
	function automatic logic [31:0] step_addr(input logic [31:0] addr, input logic [1:0] mode,
			input logic [1:0] unit, input logic deref);
		logic [31:0] amount;
		logic [31:0] res;
		amount = STEP_ONE << unit;
		if (unit == UNIT_16B) begin
			amount = STEP_16B;
		end
		if (deref) begin
			amount = STEP_WORD;
		end
		case (mode)
			STEP_INC: res = addr + amount;
			STEP_DEC: res = addr - amount;
			default: res = addr;
		endcase
		return res;
	endfunction

	function automatic logic is_deref(input logic [1:0] ch, input logic [31:0] ctrl);
		return (ch == 2'h3) && ctrl[BIT_DEREF];
	endfunction

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		logic [1:0] ch;
		logic [31:0] cw;
		logic [1:0] pick;
		logic found;
		logic act;
		ch = 2'h0;
		cw = 32'h0000_0000;
		pick = 2'h0;
		found = 1'b0;
		act = 1'b0;
		r_next = r;
		fifo_push = 1'b0;
		fifo_pop = 1'b0;
		r_next.hreadyout_reg = 1'b1;
		r_next.hresp_reg = 1'b0;

		// register write, data phase
		if (r.dp_write_reg) begin
			ch = r.dp_idx_reg[3:2];
			if (r.dp_idx_reg[1:0] == REG_CTRL) begin
				cw = hwdata & ctrl_mask(ch);
				if (!hwdata[BIT_ENABLE]) begin
					cw = cw | (r.ctrl_reg[ch] & MASK_DONE);
				end
				r_next.ctrl_reg[ch] = cw;
			end else if (r.dp_idx_reg[1:0] == REG_SRC) begin
				r_next.src_reg[ch] = hwdata;
			end else if (r.dp_idx_reg[1:0] == REG_DST) begin
				r_next.dst_reg[ch] = hwdata;
			end else begin
				r_next.cnt_reg[ch] = hwdata[CNT_W-1:0];
			end
		end

		// address phase
		r_next.dp_write_reg = 1'b0;
		if (hsel && htrans[1] && hready) begin
			r_next.hrdata_reg = 32'h0000_0000;
			if (haddr[31:MAP_TOP_BIT] != '0) begin
				r_next.dp_write_reg = 1'b0;
			end else if (hwrite) begin
				r_next.dp_write_reg = 1'b1;
				r_next.dp_idx_reg = haddr[5:2];
			end else if (haddr[3:2] == REG_CTRL) begin
				r_next.hrdata_reg = r.ctrl_reg[haddr[5:4]];
			end else if (haddr[3:2] == REG_SRC) begin
				r_next.hrdata_reg = r.src_reg[haddr[5:4]];
			end else if (haddr[3:2] == REG_DST) begin
				r_next.hrdata_reg = r.dst_reg[haddr[5:4]];
			end else begin
				r_next.hrdata_reg = {{(32 - CNT_W){1'b0}}, r.cnt_reg[haddr[5:4]]};
			end
		end

		// transfer sequencer
		ch = r.cur_reg;
		cw = r.ctrl_reg[ch];
		case (r.state_reg)
			ST_IDLE: begin
				for (int i = NUM_CH - 1; i >= 0; i--) begin
					if (r.ctrl_reg[i][BIT_ENABLE]) begin
						found = 1'b1;
						pick = 2'(i);
					end
				end
				if (found) begin
					r_next.cur_reg = pick;
					r_next.rd_left_reg = r.cnt_reg[pick];
					r_next.state_reg = ST_SCHED;
				end
			end
			// one cycle after each beat, so the fifo flags are settled
			ST_SCHED: begin
				if (r.rd_left_reg != '0 && fifo_in_ready) begin
					r_next.mem_req_reg = 1'b1;
					r_next.mem_write_reg = 1'b0;
					r_next.mem_addr_reg = r.src_reg[ch];
					if (is_deref(ch, cw)) begin
						r_next.mem_size_reg = UNIT_32;
						r_next.state_reg = ST_IND;
					end else begin
						r_next.mem_size_reg = cw[UNIT_LSB+:2];
						r_next.state_reg = ST_RD;
					end
				end else if (fifo_out_valid) begin
					r_next.mem_req_reg = 1'b1;
					r_next.mem_write_reg = 1'b1;
					r_next.mem_addr_reg = r.dst_reg[ch];
					r_next.mem_size_reg = cw[UNIT_LSB+:2];
					r_next.mem_wdata_reg = fifo_out_data;
					r_next.state_reg = ST_WR;
				end else begin
					r_next.ctrl_reg[ch][BIT_ENABLE] = 1'b0;
					r_next.ctrl_reg[ch][BIT_DONE] = 1'b1;
					r_next.state_reg = ST_IDLE;
				end
			end
			ST_IND: begin
				if (mem_ready) begin
					r_next.mem_addr_reg = mem_rdata[31:0];
					r_next.mem_size_reg = cw[UNIT_LSB+:2];
					r_next.state_reg = ST_RD;
				end
			end
			ST_RD: begin
				if (mem_ready) begin
					fifo_push = 1'b1;
					r_next.mem_req_reg = 1'b0;
					r_next.rd_left_reg = r.rd_left_reg - 1'b1;
					r_next.src_reg[ch] = step_addr(r.src_reg[ch], cw[SRC_STEP_LSB+:2], cw[UNIT_LSB+:2],
						is_deref(ch, cw));
					r_next.state_reg = ST_SCHED;
				end
			end
			ST_WR: begin
				if (mem_ready) begin
					fifo_pop = 1'b1;
					r_next.mem_req_reg = 1'b0;
					r_next.cnt_reg[ch] = r.cnt_reg[ch] - 1'b1;
					r_next.dst_reg[ch] = step_addr(r.dst_reg[ch], cw[DEST_STEP_LSB+:2], cw[UNIT_LSB+:2],
						1'b0);
					r_next.state_reg = ST_SCHED;
				end
			end
			default: begin
				r_next.state_reg = ST_IDLE;
			end
		endcase
		r_next.busy_reg = (r_next.state_reg != ST_IDLE);

		// acknowledge strobes follow the cycle that the bus is about to run
		for (int i = 0; i < 2; i++) begin
			act = r_next.mem_req_reg && (r_next.cur_reg == 2'(i)) &&
				(r_next.ctrl_reg[i][BIT_ACK_PHASE] ? (r_next.state_reg == ST_WR)
					: (r_next.state_reg == ST_RD));
			r_next.ack_reg[i] = act ? r_next.ctrl_reg[i][BIT_ACK_POLARITY]
				: ~r_next.ctrl_reg[i][BIT_ACK_POLARITY];
		end
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r.ctrl_reg <= {NUM_CH{CTRL_RESET}};
			r.src_reg <= '0;
			r.dst_reg <= '0;
			r.cnt_reg <= '0;
			r.state_reg <= ST_IDLE;
			r.cur_reg <= 2'h0;
			r.rd_left_reg <= '0;
			r.dp_write_reg <= 1'b0;
			r.dp_idx_reg <= 4'h0;
			r.hrdata_reg <= 32'h0000_0000;
			r.hreadyout_reg <= 1'b1;
			r.hresp_reg <= 1'b0;
			r.mem_req_reg <= 1'b0;
			r.mem_write_reg <= 1'b0;
			r.mem_addr_reg <= 32'h0000_0000;
			r.mem_size_reg <= 2'h0;
			r.mem_wdata_reg <= '0;
			r.ack_reg <= 2'h3;
			r.busy_reg <= 1'b0;
		end else begin
			r <= r_next;
		end
	end

	// -----------------------------------------------------------------
	// read data buffer
	// -----------------------------------------------------------------
	dmaac_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(mem_rdata),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	assign hreadyout = r.hreadyout_reg;
	assign hresp = r.hresp_reg;
	assign hrdata = r.hrdata_reg;
	assign mem_req = r.mem_req_reg;
	assign mem_write = r.mem_write_reg;
	assign mem_addr = r.mem_addr_reg;
	assign mem_size = r.mem_size_reg;
	assign mem_wdata = r.mem_wdata_reg;
	assign transfer_ack_out = r.ack_reg;
	assign busy = r.busy_reg;

endmodule

// -----------------------------------------------------------------
// synchronous fifo
// -----------------------------------------------------------------
module dmaac_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
		logic [AW-1:0] wp_reg;
		logic [AW-1:0] rp_reg;
		logic [AW:0] cnt_reg;
	} dmaac_fifo_state_type;

	dmaac_fifo_state_type f;
	dmaac_fifo_state_type f_next;
	logic push;
	logic pop;

	assign in_ready = (f.cnt_reg != (AW + 1)'(DEPTH));
	assign out_valid = (f.cnt_reg != '0);
	assign out_data = f.mem_reg[f.rp_reg];

	always_comb begin
		push = in_valid && in_ready;
		pop = out_ready && out_valid;
		f_next = f;
		if (push) begin
			f_next.mem_reg[f.wp_reg] = in_data;
			f_next.wp_reg = (f.wp_reg == AW'(DEPTH - 1)) ? '0 : f.wp_reg + 1'b1;
		end
		if (pop) begin
			f_next.rp_reg = (f.rp_reg == AW'(DEPTH - 1)) ? '0 : f.rp_reg + 1'b1;
		end
		if (push && !pop) begin
			f_next.cnt_reg = f.cnt_reg + 1'b1;
		end else if (pop && !push) begin
			f_next.cnt_reg = f.cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			f <= '0;
		end else begin
			f <= f_next;
		end
	end

endmodule

// ==== design/dmaac_pkg.sv ====
package dmaac_pkg;

	// -----------------------------------------------------------------
	// register map (byte offsets within a 16-byte channel slot)
	// -----------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_SRC = 2'h1;
	localparam logic [1:0] REG_DST = 2'h2;
	localparam logic [1:0] REG_CNT = 2'h3;
	localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFS_SRC = 32'h0000_0004;
	localparam logic [31:0] OFS_DST = 32'h0000_0008;
	localparam logic [31:0] OFS_CNT = 32'h0000_000C;
	localparam logic [31:0] CH_STRIDE = 32'h0000_0010;
	localparam int MAP_TOP_BIT = 6;

	// -----------------------------------------------------------------
	// channel control register fields
	// -----------------------------------------------------------------
	localparam int BIT_ENABLE = 0;
	localparam int BIT_DONE = 1;
	localparam int UNIT_LSB = 3;
	localparam int SRC_STEP_LSB = 12;
	localparam int DEST_STEP_LSB = 14;
	localparam int BIT_ACK_POLARITY = 16;
	localparam int BIT_ACK_PHASE = 17;
	localparam int BIT_DEREF = 20;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_COMMON = 32'h0000_F019;
	localparam logic [31:0] MASK_ACK = 32'h0003_0000;
	localparam logic [31:0] MASK_DEREF = 32'h0010_0000;
	localparam logic [31:0] MASK_DONE = 32'h0000_0002;

	// -----------------------------------------------------------------
	// step modes and unit widths
	// -----------------------------------------------------------------
	localparam logic [1:0] STEP_FIXED = 2'h0;
	localparam logic [1:0] STEP_INC = 2'h1;
	localparam logic [1:0] STEP_DEC = 2'h2;
	localparam logic [1:0] UNIT_8 = 2'h0;
	localparam logic [1:0] UNIT_16 = 2'h1;
	localparam logic [1:0] UNIT_32 = 2'h2;
	localparam logic [1:0] UNIT_16B = 2'h3;
	localparam logic [31:0] STEP_16B = 32'h0000_0010;
	localparam logic [31:0] STEP_WORD = 32'h0000_0004;
	localparam logic [31:0] STEP_ONE = 32'h0000_0001;

	// -----------------------------------------------------------------
	// sequencer states, one-hot
	// -----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SCHED = 5'h02,
		ST_IND = 5'h04,
		ST_RD = 5'h08,
		ST_WR = 5'h10
	} dmaac_fsm_type;

	localparam int CNT_W = 24;
	localparam int FIFO_DEPTH = 8;

endpackage

// ==== tb/dmaac_props.sv ====
`timescale 1ns/1ps
// ----
// ack and memory port checks
// ----
module dmaac_props (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	// memory port and ack
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic mem_ready,
	input wire logic [1:0] transfer_ack_out,
	input wire logic busy
);
	logic wr_q;
	logic [31:0] a_q;
	logic [1:0] pol;
	logic [1:0] ph;
	// shadow of the ch0/ch1 ack fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'h0;
			a_q <= 32'h0;
			pol <= 2'h0;
			ph <= 2'h0;
		end else begin
			wr_q <= hsel && htrans[1] && hready && hwrite;
			a_q <= haddr;
			if (wr_q && (a_q & 32'hFFFF_FFEF) == 32'h0) begin
				pol[a_q[4]] <= hwdata[16];
				ph[a_q[4]] <= hwdata[17];
			end
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_ack_idle;
		!mem_req && $stable(pol) |-> transfer_ack_out == ~pol;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack not idle");
	property p_ack_act0;
		transfer_ack_out[0] == pol[0] && $stable(pol) |-> mem_req && mem_write == ph[0];
	endproperty
	a_ack_act0: assert property (p_ack_act0) else $error("ch0 ack wrong cycle");
	property p_ack_act1;
		transfer_ack_out[1] == pol[1] && $stable(pol) |-> mem_req && mem_write == ph[1];
	endproperty
	a_ack_act1: assert property (p_ack_act1) else $error("ch1 ack wrong cycle");
	property p_ack_one;
		$stable(pol) |-> !(transfer_ack_out[0] == pol[0] && transfer_ack_out[1] == pol[1]);
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("both acks active");
	property p_hold;
		mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_write);
	endproperty
	a_hold: assert property (p_hold) else $error("request changed");
	property p_wr_drop;
		mem_req && mem_ready && mem_write |=> !mem_req;
	endproperty
	a_wr_drop: assert property (p_wr_drop) else $error("request not dropped");
	property p_busy;
		mem_req |-> busy;
	endproperty
	a_busy: assert property (p_busy) else $error("request while idle");
	property p_reset;
		$rose(hresetn) |-> !mem_req && !busy && transfer_ack_out == 2'h3;
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	c_rd_ack: cover property (transfer_ack_out[0] == pol[0] && !mem_write);
	c_wr_ack: cover property (transfer_ack_out[1] == pol[1] && mem_write);
	c_ptr: cover property (mem_req && mem_ready && !mem_write ##1 mem_req);
endmodule

bind dmaac_top dmaac_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .mem_req(mem_req),
	.mem_write(mem_write), .mem_addr(mem_addr), .mem_ready(mem_ready),
	.transfer_ack_out(transfer_ack_out), .busy(busy));

// ==== tb/dmaac_mem_model.sv ====
`timescale 1ns/1ps
// ----
// memory and peripheral stand-in
// ----
module dmaac_mem_model (
	// clock
	input wire logic hclk,
	// memory port
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_wdata,
	output logic mem_ready,
	output logic [31:0] mem_rdata,
	// ack strobes
	input wire logic [1:0] transfer_ack_out
);
	int lat = 0;
	int wait_n = 0;
	logic [31:0] rd_q[$];
	logic [31:0] wr_q[$];
	logic [1:0] rda_q[$];
	logic [1:0] wra_q[$];
	logic [31:0] wd_q[$];
	logic [1:0] sz_q[$];
	initial begin
		mem_ready = 1'h0;
		mem_rdata = 32'h0;
	end
	always @(posedge hclk) begin
		if (mem_req && !mem_ready && wait_n >= lat) begin
			mem_ready <= 1'h1;
			// stored pointer sits 0x100 above its slot
			mem_rdata <= mem_addr + 32'h100;
		end else begin
			// released data line never keeps its last value
			mem_rdata <= ~mem_rdata;
			mem_ready <= 1'h0;
			wait_n <= (mem_req && !mem_ready) ? wait_n + 1 : 0;
		end
		if (mem_req && mem_ready && mem_write) begin
			wr_q.push_back(mem_addr);
			wra_q.push_back(transfer_ack_out);
			wd_q.push_back(mem_wdata);
			sz_q.push_back(mem_size);
		end
		if (mem_req && mem_ready && !mem_write) begin
			rd_q.push_back(mem_addr);
			rda_q.push_back(transfer_ack_out);
		end
	end
endmodule

// ==== tb/tb_dma_channel_addr_ack_control.sv ====
`timescale 1ns/1ps
module tb_dma_channel_addr_ack_control;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, mem_req, mem_write, mem_ready, busy;
	logic [1:0] htrans, mem_size, ack;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, r;
	int n_mismatch, check_count;

	dmaac_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
		.mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
		.transfer_ack_out(ack), .busy(busy));
	dmaac_mem_model MEM (.hclk(hclk), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
		.mem_size(mem_size), .mem_wdata(mem_wdata),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata), .transfer_ack_out(ack));

	initial begin
		hclk = 1'h0;
		forever #12.5 hclk = ~hclk;
	end

	// ----
	// helpers
	// ----
	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'h1) begin
			n++;
			if (n > 50) begin
				n_mismatch++;
				stop_test();
			end
			@(posedge hclk);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask

	function automatic logic [31:0] step(input logic [1:0] m, input logic [1:0] u);
		if (m == 2'h1) return (u == 2'h3) ? 32'h10 : 32'h1 << u;
		if (m == 2'h2) return 32'h0 - (32'h1 << u);
		return 32'h0;
	endfunction

	// two units on channel ch, then addresses and acks judged
	task automatic xfer(input logic [1:0] ch, input logic [31:0] c, input logic [31:0] s, input logic [31:0] d);
		logic [31:0] b, ss, ds;
		logic ind;
		b = {26'h0, ch, 4'h0};
		ind = c[20] && ch == 2'h3;
		ss = step(c[13:12], ind ? 2'h2 : c[4:3]);
		ds = step(c[15:14], c[4:3]);
		MEM.rd_q.delete();
		MEM.wr_q.delete();
		MEM.rda_q.delete();
		MEM.wra_q.delete();
		MEM.wd_q.delete();
		MEM.sz_q.delete();
		ahb(1'h1, b + 32'h4, s);
		ahb(1'h1, b + 32'h8, d);
		ahb(1'h1, b + 32'hC, 32'h2);
		ahb(1'h1, b, c | 32'h1);
		// stale read data must not pass for the done flag
		r = 32'h0;
		for (int n = 0; n < 100 && r[1] !== 1'h1; n++) begin
			ahb(1'h0, b, 32'h0);
		end
		if (r[1] !== 1'h1) begin
			n_mismatch++;
			stop_test();
		end
		chk(32'h0, {30'h0, busy, hresp});
		chk(ind ? 32'h4 : 32'h2, MEM.rd_q.size());
		chk(32'h2, MEM.wr_q.size());
		for (int k = 0; k < 2; k++) begin
			if (ind) begin
				chk(s + k * ss, MEM.rd_q[2 * k]);
				chk(s + k * ss + 32'h100, MEM.rd_q[2 * k + 1]);
			end else begin
				chk(s + k * ss, MEM.rd_q[k]);
			end
			chk(d + k * ds, MEM.wr_q[k]);
			chk(s + k * ss + (ind ? 32'h200 : 32'h100), MEM.wd_q[k]);
			chk({30'h0, c[4:3]}, {30'h0, MEM.sz_q[k]});
			if (ch < 2'h2) begin
				chk({31'h0, c[16] ^ c[17]}, {31'h0, MEM.rda_q[k][ch]});
				chk({31'h0, ~(c[16] ^ c[17])}, {31'h0, MEM.wra_q[k][ch]});
			end
		end
		ahb(1'h0, b + 32'h4, 32'h0);
		chk(s + 2 * ss, r);
		ahb(1'h0, b + 32'h8, 32'h0);
		chk(d + 2 * ds, r);
	endtask

	// ----
	// scenarios
	// ----
	task automatic sc_reset_values();
		for (int a = 0; a < 64; a += 4) begin
			ahb(1'h0, a, 32'h0);
			chk(32'h0, r);
		end
		ahb(1'h1, 32'h40, 32'hFFFF_FFFF);
		ahb(1'h0, 32'h40, 32'h0);
		chk(32'h0, r);
		// an unmapped write must not alias onto channel 0
		ahb(1'h0, 32'h0, 32'h0);
		chk(32'h0, r);
	endtask

	task automatic sc_field_masks();
		for (int ch = 0; ch < 4; ch++) begin
			ahb(1'h1, ch * 16, 32'h0013_F018);
			ahb(1'h0, ch * 16, 32'h0);
			chk(32'hF018 | (ch < 2 ? 32'h3_0000 : 32'h0) | (ch == 3 ? 32'h10_0000 : 32'h0), r);
			ahb(1'h1, ch * 16, 32'h0);
		end
	endtask

	task automatic sc_step_table();
		logic [31:0] c;
		for (int u = 0; u < 4; u++) begin
			for (int m = 0; m < 3; m++) begin
				// only increment with 16-byte units
				if (u < 3 || m == 1) begin
					MEM.lat = m;
					c = 32'(((2 - m) << 14) | (m << 12) | (u << 3) | (((u + m) % 4) << 16));
					xfer(2'((u + m) % 3), c, 32'h1000, 32'h2000);
				end
			end
		end
	endtask

	task automatic sc_indirect();
		MEM.lat = 1;
		xfer(2'h3, 32'h0010_1000, 32'h3000, 32'h4000);
		xfer(2'h3, 32'h0010_2008, 32'h3000, 32'h4000);
	endtask

	// write-cycle acks and both polarities on channel 1, an active-high read-cycle ack on channel 0
	task automatic sc_ack_modes();
		MEM.lat = 0;
		xfer(2'h1, 32'h0002_5010, 32'h5000, 32'h6000);
		xfer(2'h1, 32'h0003_5008, 32'h5000, 32'h6000);
		xfer(2'h0, 32'h0001_A010, 32'h5000, 32'h6000);
	endtask

	initial begin
		n_mismatch = 0;
		check_count = 0;
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		r = 32'h0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		sc_reset_values();
		sc_field_masks();
		sc_step_table();
		sc_indirect();
		sc_ack_modes();
		stop_test();
	end
endmodule
